// ===== ssb_map.vh
`ifndef SSB_MAP_VH
`define SSB_MAP_VH
// byte lane geometry
`define SSB_BYTE_W 8
`define SSB_LANE_W 9
`define SSB_MAX_LANES 4
`define SSB_PIN_BUS_W 36
// burst counter
`define SSB_BEAT_W 2
`define SSB_BEAT_STEP 2'h1
`define SSB_BEAT_FIRST 2'h0
// defaults for the 256K x 18 variant
`define SSB_DEF_ADDR_W 18
`define SSB_DEF_LANES 2
`define SSB_DEF_PARITY 1
// reset values
`define SSB_ORDER_RST 1'b1
`define SSB_SNOOZE_RST 1'b0
`endif

// ===== ssb_mem.v
`timescale 1ns/1ns
module ssb_mem #(
  parameter AW = 18,
  parameter LANES = 2,
  parameter LW = 9
) (
  // clock
  input wire clock,
  // write port
  input wire wr_en,
  input wire [LANES-1:0] wr_lane,
  input wire [AW-1:0] wr_addr,
  input wire [LANES*LW-1:0] wr_data,
  // read port, data registered
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output wire [LANES*LW-1:0] rd_data
);
  genvar i;
  generate
    for (i = 0; i < LANES; i = i + 1)
    begin : g_lane
      reg [LW-1:0] mem [0:(1<<AW)-1];
      reg [LW-1:0] q_r;
      always @(posedge clock)
      begin
        if (wr_en && wr_lane[i])
          mem[wr_addr] <= wr_data[i*LW +: LW];
        if (rd_en)
          q_r <= mem[rd_addr];
      end
      assign rd_data[i*LW +: LW] = q_r;
    end
  endgenerate
endmodule

// ===== ssb_ctrl.v
`timescale 1ns/1ns
`include "ssb_map.vh"
// What this block does
// - advance high steps the internal burst counter
// - read/write select ignored while advancing
// - advance/load low captures a fresh address
// - order select low linear, high interleaved
// - data bus split into byte lanes
// - one parity bit per lane, none on x32
// - cycle type set only at address load
// - chip selects sampled only at load
// - byte write enables gate lane and parity
// - clock enable high freezes all state except the order and snooze synchronisers and, while snoozed, the output enables
module ssb_ctrl #(
  parameter AW = `SSB_DEF_ADDR_W,
  parameter LANES = `SSB_DEF_LANES,
  parameter PARITY = `SSB_DEF_PARITY
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  // address and control
  input wire [AW-3:0] addr_hi,
  input wire burst_addr_bit0,
  input wire burst_addr_bit1,
  input wire addr_advance_load_n,
  input wire read_write_n,
  input wire chip_sel_n,
  input wire chip_sel_low_n,
  input wire chip_sel_high,
  input wire clock_en_n,
  input wire burst_order_sel,
  input wire snooze_request,
  // byte write enables
  input wire lane_a_write_en_n,
  input wire lane_b_write_en_n,
  input wire lane_c_write_en_n,
  input wire lane_d_write_en_n,
  // lane a
  input wire [7:0] byte_lane_a_in,
  output wire [7:0] byte_lane_a_out,
  output wire byte_lane_a_oe,
  input wire lane_a_parity_in,
  output wire lane_a_parity_out,
  output wire lane_a_parity_oe,
  // lane b
  input wire [7:0] byte_lane_b_in,
  output wire [7:0] byte_lane_b_out,
  output wire byte_lane_b_oe,
  input wire lane_b_parity_in,
  output wire lane_b_parity_out,
  output wire lane_b_parity_oe,
  // lane c
  input wire [7:0] byte_lane_c_in,
  output wire [7:0] byte_lane_c_out,
  output wire byte_lane_c_oe,
  input wire lane_c_parity_in,
  output wire lane_c_parity_out,
  output wire lane_c_parity_oe,
  // lane d
  input wire [7:0] byte_lane_d_in,
  output wire [7:0] byte_lane_d_out,
  output wire byte_lane_d_oe,
  input wire lane_d_parity_in,
  output wire lane_d_parity_out,
  output wire lane_d_parity_oe
);
  localparam LW = (PARITY != 0) ? `SSB_LANE_W : `SSB_BYTE_W;
  localparam DW = LANES * LW;

  function [`SSB_BEAT_W-1:0] beat_addr;
    input [`SSB_BEAT_W-1:0] start;
    input [`SSB_BEAT_W-1:0] n;
    input linear;
    begin
      beat_addr = linear ? start + n : start ^ n;
    end
  endfunction

  reg order_s1_r;
  reg order_r;
  reg snooze_s1_r;
  reg snooze_r;
  reg [AW-1:0] base_r;
  reg [`SSB_BEAT_W-1:0] cnt_r;
  reg wr_r;
  reg sel_r;
  reg s1_valid_r;
  reg s1_wr_r;
  reg [AW-1:0] s1_addr_r;
  reg [`SSB_MAX_LANES-1:0] s1_be_r;
  reg s2_valid_r;
  reg s2_wr_r;
  reg [AW-1:0] s2_addr_r;
  reg [`SSB_MAX_LANES-1:0] s2_be_r;
  reg [`SSB_PIN_BUS_W-1:0] out_r;
  reg [2*`SSB_MAX_LANES-1:0] oe_r;

  reg [AW-1:0] base_nxt;
  reg [`SSB_BEAT_W-1:0] cnt_nxt;
  reg wr_nxt;
  reg sel_nxt;
  reg [AW-1:0] acc_addr;

  wire hold = clock_en_n | snooze_r;
  wire load = ~addr_advance_load_n;
  wire ce_ok = ~chip_sel_n & ~chip_sel_low_n & chip_sel_high;
  wire [`SSB_BEAT_W-1:0] start = {burst_addr_bit1, burst_addr_bit0};
  wire [`SSB_BEAT_W-1:0] cnt_adv = cnt_r + `SSB_BEAT_STEP;
  wire [`SSB_BEAT_W-1:0] low_adv;
  wire [`SSB_MAX_LANES-1:0] be_pins = ~{lane_d_write_en_n,
    lane_c_write_en_n, lane_b_write_en_n, lane_a_write_en_n};
  wire [`SSB_PIN_BUS_W-1:0] pin_bus = {
    lane_d_parity_in, byte_lane_d_in, lane_c_parity_in, byte_lane_c_in,
    lane_b_parity_in, byte_lane_b_in, lane_a_parity_in, byte_lane_a_in};
  wire [DW-1:0] wr_data;
  wire [DW-1:0] rd_data;
  wire [`SSB_PIN_BUS_W-1:0] rd_wide;
  wire [`SSB_MAX_LANES-1:0] lane_on;
  wire [`SSB_MAX_LANES-1:0] be_lanes = be_pins & lane_on;
  wire [2*`SSB_MAX_LANES-1:0] oe_mask;
  wire mem_rd = ~hold & s1_valid_r & ~s1_wr_r;
  wire mem_wr = ~hold & s2_valid_r & s2_wr_r;

  assign low_adv = beat_addr(base_r[`SSB_BEAT_W-1:0], cnt_adv, ~order_r);

  genvar i;
  generate
    for (i = 0; i < `SSB_MAX_LANES; i = i + 1)
    begin : g_lane
      if (i < LANES)
      begin : g_on
        assign lane_on[i] = 1'b1;
        assign oe_mask[`SSB_MAX_LANES+i] = (PARITY != 0);
        if (PARITY != 0)
        begin : g_par
          assign wr_data[i*LW +: LW] = pin_bus[i*`SSB_LANE_W +: LW];
          assign rd_wide[i*`SSB_LANE_W +: `SSB_LANE_W] = rd_data[i*LW +: LW];
        end
        else
        begin : g_nopar
          assign wr_data[i*LW +: LW] = pin_bus[i*`SSB_LANE_W +: LW];
          assign rd_wide[i*`SSB_LANE_W +: `SSB_LANE_W] =
            {1'b0, rd_data[i*LW +: LW]};
        end
      end
      else
      begin : g_off
        assign lane_on[i] = 1'b0;
        assign oe_mask[`SSB_MAX_LANES+i] = 1'b0;
        assign rd_wide[i*`SSB_LANE_W +: `SSB_LANE_W] = {`SSB_LANE_W{1'b0}};
      end
      assign oe_mask[i] = lane_on[i];
    end
  endgenerate

  always @*
  begin
    base_nxt = base_r;
    cnt_nxt = cnt_adv;
    wr_nxt = wr_r;
    sel_nxt = sel_r;
    acc_addr = {base_r[AW-1:`SSB_BEAT_W], low_adv};
    if (load)
    begin
      base_nxt = {addr_hi, start};
      cnt_nxt = `SSB_BEAT_FIRST;
      acc_addr = {addr_hi, start};
      wr_nxt = ~read_write_n;
      sel_nxt = ce_ok;
    end
  end

  // strap and snooze inputs come from outside the clocked logic
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      order_s1_r <= `SSB_ORDER_RST;
      order_r <= `SSB_ORDER_RST;
      snooze_s1_r <= `SSB_SNOOZE_RST;
      snooze_r <= `SSB_SNOOZE_RST;
    end
    else
    begin
      order_s1_r <= burst_order_sel;
      order_r <= order_s1_r;
      snooze_s1_r <= snooze_request;
      snooze_r <= snooze_s1_r;
    end
  end

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      base_r <= {AW{1'b0}};
      cnt_r <= `SSB_BEAT_FIRST;
      wr_r <= 1'b0;
      sel_r <= 1'b0;
      s1_valid_r <= 1'b0;
      s1_wr_r <= 1'b0;
      s1_addr_r <= {AW{1'b0}};
      s1_be_r <= {`SSB_MAX_LANES{1'b0}};
      s2_valid_r <= 1'b0;
      s2_wr_r <= 1'b0;
      s2_addr_r <= {AW{1'b0}};
      s2_be_r <= {`SSB_MAX_LANES{1'b0}};
    end
    else if (!hold)
    begin
      base_r <= base_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      sel_r <= sel_nxt;
      s1_valid_r <= sel_nxt;
      s1_wr_r <= wr_nxt;
      s1_addr_r <= acc_addr;
      s1_be_r <= be_lanes;
      s2_valid_r <= s1_valid_r;
      s2_wr_r <= s1_wr_r;
      s2_addr_r <= s1_addr_r;
      s2_be_r <= s1_be_r;
    end
  end

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      out_r <= {`SSB_PIN_BUS_W{1'b0}};
      oe_r <= {2*`SSB_MAX_LANES{1'b0}};
    end
    else if (snooze_r)
      oe_r <= {2*`SSB_MAX_LANES{1'b0}};
    else if (!clock_en_n)
    begin
      if (s2_valid_r && !s2_wr_r)
      begin
        out_r <= rd_wide;
        oe_r <= oe_mask;
      end
      else
        oe_r <= {2*`SSB_MAX_LANES{1'b0}};
    end
  end

  ssb_mem #(
    .AW(AW),
    .LANES(LANES),
    .LW(LW)
  ) u_mem (
    .clock(clock),
    .wr_en(mem_wr),
    .wr_lane(s2_be_r[LANES-1:0]),
    .wr_addr(s2_addr_r),
    .wr_data(wr_data),
    .rd_en(mem_rd),
    .rd_addr(s1_addr_r),
    .rd_data(rd_data)
  );

  assign byte_lane_a_out = out_r[7:0];
  assign lane_a_parity_out = out_r[8];
  assign byte_lane_b_out = out_r[16:9];
  assign lane_b_parity_out = out_r[17];
  assign byte_lane_c_out = out_r[25:18];
  assign lane_c_parity_out = out_r[26];
  assign byte_lane_d_out = out_r[34:27];
  assign lane_d_parity_out = out_r[35];
  assign byte_lane_a_oe = oe_r[0];
  assign byte_lane_b_oe = oe_r[1];
  assign byte_lane_c_oe = oe_r[2];
  assign byte_lane_d_oe = oe_r[3];
  assign lane_a_parity_oe = oe_r[4];
  assign lane_b_parity_oe = oe_r[5];
  assign lane_c_parity_oe = oe_r[6];
  assign lane_d_parity_oe = oe_r[7];
endmodule

// ===== ssb_ctrl_properties.sv
`timescale 1ns/1ns
module ssb_ctrl_properties #(
  parameter LANES = 2,
  parameter PARITY = 1
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  // request
  input wire addr_advance_load_n,
  input wire read_write_n,
  input wire chip_sel_n,
  input wire chip_sel_low_n,
  input wire chip_sel_high,
  input wire clock_en_n,
  input wire snooze_request,
  // lanes
  input wire [7:0] byte_lane_a_out,
  input wire byte_lane_a_oe,
  input wire byte_lane_b_oe,
  input wire byte_lane_c_oe,
  input wire lane_a_parity_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire sel = !chip_sel_n && !chip_sel_low_n && chip_sel_high;
  wire go = !clock_en_n && !snooze_request;
  sequence s_load(t);
    go && !addr_advance_load_n && sel && read_write_n == t;
  endsequence
  // two further active edges carry a request to the output stage
  sequence s_two;
    go ##1 go;
  endsequence
  chk_read_drives: assert property (
    s_load(1'b1) ##1 s_two |=> byte_lane_a_oe)
    else $error("read load left lanes idle");
  chk_write_quiet: assert property (
    s_load(1'b0) ##1 s_two |=> !byte_lane_a_oe)
    else $error("write load drove lanes");
  chk_desel_quiet: assert property (
    go && !addr_advance_load_n && !sel ##1 s_two |=> !byte_lane_a_oe)
    else $error("deselected load drove lanes");
  chk_adv_keeps_type: assert property (
    s_load(1'b1) ##1 (go && addr_advance_load_n && !read_write_n)
    ##1 s_two |=> byte_lane_a_oe)
    else $error("advance changed cycle type");
  chk_freeze_hold: assert property (
    clock_en_n |=> $stable(byte_lane_a_out) && $stable(byte_lane_a_oe))
    else $error("state moved while clock disabled");
  chk_lanes_pair: assert property (
    byte_lane_b_oe == byte_lane_a_oe)
    else $error("lanes a and b disagree");
  chk_parity_pair: assert property (
    PARITY == 1 |-> lane_a_parity_oe == byte_lane_a_oe)
    else $error("parity enable apart from lane");
  chk_unused_lane: assert property (
    LANES < 3 |-> !byte_lane_c_oe)
    else $error("absent lane driven");
endmodule

bind ssb_ctrl ssb_ctrl_properties #(.LANES(LANES), .PARITY(PARITY))
  u_props (.*);

// ===== ssb_host.sv
`timescale 1ns/1ns
module ssb_host (
  // clock
  input wire clock,
  // request lines
  output reg [17:0] addr,
  output reg ld_n,
  output reg rw_n,
  output reg sel_n,
  output reg cke_n,
  output reg [1:0] bw_n,
  output reg order,
  // data lanes
  input wire [17:0] dev_q,
  input wire [1:0] dev_oe,
  output wire [17:0] bus
);
  reg [17:0] hd;
  reg hw = 1'b0;
  initial {ld_n, rw_n, sel_n, cke_n, bw_n, addr, hd, order} = {6'h3f, 37'h0};
  // a released lane shows the inverse of its last value
  // write data wins over a read beat still standing on the lanes
  assign bus[8:0] = (dev_oe[0] && !hw) ? dev_q[8:0] : hd[8:0];
  assign bus[17:9] = (dev_oe[1] && !hw) ? dev_q[17:9] : hd[17:9];
  task strap(input v);
    order = v;
  endtask
  task drive(input l, input r, input [17:0] a, input s, input k,
    input [1:0] b, input w, input [17:0] d);
    begin
      ld_n <= l;
      rw_n <= r;
      addr <= a;
      sel_n <= s;
      cke_n <= k;
      bw_n <= b;
      hd <= w ? d : ~hd;
      hw <= w;
    end
  endtask
endmodule

// ===== test_sync_sram_burst_address_control.sv
`timescale 1ns/1ns
module test_sync_sram_burst_address_control;
  logic clock, resetn, ld_n, rw_n, sel_n, cke_n, order;
  logic [17:0] addr, bus, dq, ex_d, wd, qcd;
  logic [1:0] bw_n, oe, poe, ocd, pcd, st, n;
  logic [21:0] p0, p1;
  logic [15:0] hi;
  logic [8:0] salt;
  logic wt, sv, ex_oe, w;
  logic [17:0] mem [logic [17:0]];
  int error_cnt, total_checks;
  // row: load_n, rw_n, select, clock_en_n, write_en_n b/a, start bits
  logic [7:0] rows [18] = '{8'h21, 8'hc0, 8'hc0, 8'hc0, 8'hd0, 8'hcc,
    8'h62, 8'h80, 8'h80, 8'h80, 8'h2b, 8'h00, 8'h60, 8'h63, 8'hd0, 8'hc0,
    8'h40, 8'h40};
  ssb_host host (.clock(clock), .addr(addr), .ld_n(ld_n), .rw_n(rw_n),
    .sel_n(sel_n), .cke_n(cke_n), .bw_n(bw_n), .order(order),
    .dev_q(dq), .dev_oe(oe), .bus(bus));
  ssb_ctrl DUT (.clock(clock), .resetn(resetn), .addr_hi(addr[17:2]),
    .burst_addr_bit0(addr[0]), .burst_addr_bit1(addr[1]),
    .addr_advance_load_n(ld_n), .read_write_n(rw_n),
    .chip_sel_n(sel_n), .chip_sel_low_n(sel_n), .chip_sel_high(!sel_n),
    .clock_en_n(cke_n), .burst_order_sel(order), .snooze_request(1'b0),
    .lane_a_write_en_n(bw_n[0]), .lane_b_write_en_n(bw_n[1]),
    .lane_c_write_en_n(bw_n[0]), .lane_d_write_en_n(bw_n[1]),
    .byte_lane_a_in(bus[7:0]), .byte_lane_a_out(dq[7:0]),
    .byte_lane_a_oe(oe[0]), .lane_a_parity_in(bus[8]),
    .lane_a_parity_out(dq[8]), .lane_a_parity_oe(poe[0]),
    .byte_lane_b_in(bus[16:9]), .byte_lane_b_out(dq[16:9]),
    .byte_lane_b_oe(oe[1]), .lane_b_parity_in(bus[17]),
    .lane_b_parity_out(dq[17]), .lane_b_parity_oe(poe[1]),
    .byte_lane_c_in(bus[7:0]), .byte_lane_c_out(qcd[7:0]),
    .byte_lane_c_oe(ocd[0]), .lane_c_parity_in(bus[8]),
    .lane_c_parity_out(qcd[8]), .lane_c_parity_oe(pcd[0]),
    .byte_lane_d_in(bus[16:9]), .byte_lane_d_out(qcd[16:9]),
    .byte_lane_d_oe(ocd[1]), .lane_d_parity_in(bus[17]),
    .lane_d_parity_out(qcd[17]), .lane_d_parity_oe(pcd[1]));
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task check(input logic [17:0] got, input logic [17:0] exp, input string m);
    begin
      total_checks++;
      if (got !== exp)
      begin
        error_cnt++;
        $display("unexpected at %0t: %s", $time, m);
      end
    end
  endtask
  task restart(input logic v);
    begin
      resetn = 1'b0;
      host.strap(v);
      repeat (12) @(negedge clock);
      check({16'h0, oe | poe}, 18'h0, "enable in reset");
      resetn = 1'b1;
      repeat (3) @(negedge clock);
      p0 = 22'h0;
      p1 = 22'h0;
      ex_oe = 1'b0;
    end
  endtask
  // one cycle: model the two-stage pipe, drive, then compare outputs
  task step(input logic [7:0] r);
    logic [17:0] a;
    begin
      if (!r[7])
      begin
        st = r[1:0];
        n = 2'h0;
        wt = !r[6];
        sv = r[5];
      end
      else if (!r[4])
        n = n + 2'h1;
      a = {hi, order ? st ^ n : st + n};
      w = 1'b0;
      if (!r[4])
      begin
        ex_oe = p1[21] && !p1[20];
        if (ex_oe)
          ex_d = mem[p1[17:0]];
        w = p1[21] && p1[20];
        salt = salt + 9'h1f;
        wd = {p1[8:0], p1[17:9]} ^ {2{salt}};
        if (w)
          mem[p1[17:0]] = {p1[19] ? mem[p1[17:0]][17:9] : wd[17:9],
            p1[18] ? mem[p1[17:0]][8:0] : wd[8:0]};
        p1 = p0;
        p0 = {sv, wt, r[3:2], a};
      end
      host.drive(r[7], r[6], r[7] ? ~a : a, !r[5], r[4], r[3:2], w, wd);
      @(negedge clock);
      check({16'h0, oe}, {16'h0, ex_oe, ex_oe}, "enable");
      if (ex_oe)
        check(dq, ex_d, "data");
      check({16'h0, poe}, {16'h0, ex_oe, ex_oe}, "parity enable");
      check({14'h0, pcd, ocd}, 18'h0, "unused lanes");
      check(qcd, 18'h0, "unused lane data");
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial
  begin
    resetn = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    hi = 16'hc35a;
    salt = 9'h0a5;
    for (int o = 0; o < 2; o++)
    begin
      restart(o[0]);
      foreach (rows[i])
        step(rows[i]);
      $display("test order %0d done", o);
    end
    // reset in mid-burst must drop the pending read
    step(8'h62);
    step(8'hc0);
    restart(1'b1);
    step(8'h40);
    step(8'h40);
    $display("test reset done");
    report_and_stop();
  end
  initial
  begin
    #20000;
    error_cnt++;
    $display("unexpected at %0t: watchdog", $time);
    report_and_stop();
  end
endmodule
